// file: tcesr_event_regs.v
// Event flag, mask, status, connection-type and user-setting register logic.
`timescale 1ns/1ps
`default_nettype none
`include "tcesr_defines.vh"

module tcesr_event_regs #(
  parameter [`TCESR_CNT_W-1:0] DSG1_CYC = `TCESR_CYC_DSG1,
  parameter [`TCESR_CNT_W-1:0] DSG2_CYC = `TCESR_CYC_DSG2,
  parameter [`TCESR_CNT_W-1:0] DSG3_CYC = `TCESR_CYC_DSG3,
  parameter [`TCESR_CNT_W-1:0] DEB0_CYC = `TCESR_CYC_DEB0,
  parameter [`TCESR_CNT_W-1:0] DEB1_CYC = `TCESR_CYC_DEB1,
  parameter [`TCESR_CNT_W-1:0] DEB2_CYC = `TCESR_CYC_DEB2,
  parameter [`TCESR_CNT_W-1:0] DEB3_CYC = `TCESR_CYC_DEB3
) (
  input wire clk_sys,
  input wire reset_n,
  input wire [7:0] reg_addr,
  input wire reg_wr_en,
  input wire [7:0] reg_wr_data,
  input wire reg_rd_en,
  output reg [7:0] reg_rd_data,
  input wire in_attached_src,
  input wire in_attached_snk,
  input wire in_debug_sink,
  input wire in_audio,
  input wire in_debug_src,
  input wire [1:0] orient_status,
  input wire vbus_valid,
  input wire vbus_safe_zero,
  input wire auto_sink_en,
  input wire auto_sink_active,
  input wire [1:0] current_level_raw,
  input wire active_cable_seen,
  input wire forced_role_fail,
  input wire forced_role_done,
  input wire discharge_request,
  output reg vbus_discharge_on,
  output wire line_disconnect_monitor_en,
  output wire [1:0] level_debounce_sel,
  output wire [1:0] discharge_time_cap,
  output wire [1:0] current_level_status,
  output reg interrupt_n
);

  localparam CW = `TCESR_CNT_W;

  // Debounce length for a level-change select code.
  function [CW-1:0] deb_len;
    input [1:0] sel;
    begin
      case (sel)
        2'h0: deb_len = DEB0_CYC;
        2'h1: deb_len = DEB1_CYC;
        2'h2: deb_len = DEB2_CYC;
        default: deb_len = DEB3_CYC;
      endcase
    end
  endfunction

  // Discharge cap length for a cap code; code zero is handled by the caller.
  function [CW-1:0] dsg_len;
    input [1:0] sel;
    begin
      case (sel)
        2'h1: dsg_len = DSG1_CYC;
        2'h2: dsg_len = DSG2_CYC;
        default: dsg_len = DSG3_CYC;
      endcase
    end
  endfunction

  reg gmask_q;
  reg [6:0] mask_pri_q;
  reg [1:0] mask_sec_q;
  reg [7:0] user_q;
  reg [6:0] flags_pri_q;
  reg [6:0] flags_pri_d;
  reg [1:0] flags_sec_q;
  reg [1:0] flags_sec_d;
  reg [4:0] att_state_q;
  reg [1:0] orient_q;
  reg vbus_q;
  reg asnk_q;
  reg [1:0] lvl_q;
  reg [1:0] lvl_cand_q;
  reg [1:0] lvl_stable_q;
  reg [CW-1:0] deb_cnt_q;
  reg [CW-1:0] dsg_cnt_q;
  reg [7:0] rd_mux;

  wire attached_now;
  wire [4:0] att_state;
  wire wr_flags_pri;
  wire wr_flags_sec;
  wire [7:0] status_val;
  wire [7:0] conn_val;
  wire [6:0] set_pri;
  wire [1:0] set_sec;
  wire pending;

  // Any of the five connected states counts as attached.
  assign attached_now = in_attached_src | in_attached_snk | in_debug_sink | in_audio | in_debug_src;
  assign att_state = {in_debug_src, in_debug_sink, in_audio, in_attached_snk, in_attached_src};

  // User setting fields steer the surrounding detection logic directly.
  assign line_disconnect_monitor_en = user_q[`TCESR_BIT_DSCNT_EN];
  assign discharge_time_cap = user_q[`TCESR_MSB_DSG:`TCESR_LSB_DSG];
  assign level_debounce_sel = user_q[`TCESR_MSB_DEB:`TCESR_LSB_DEB];

  // The level field only carries meaning in the attached sink state.
  assign current_level_status = in_attached_snk ? lvl_stable_q : 2'h0;

  // Live status word.
  assign status_val = {auto_sink_active,
                       vbus_safe_zero,
                       orient_status,
                       vbus_valid,
                       current_level_status,
                       attached_now};

  // Connection-type word; audio bits split by VBUS validity.
  assign conn_val = {1'b0,
                     in_debug_src,
                     in_debug_sink,
                     in_attached_snk,
                     in_attached_src,
                     active_cable_seen & in_attached_src,
                     in_audio & vbus_valid,
                     in_audio & ~vbus_valid};

  // Event detection from the previous sample, forced-role flags straight from their inputs; masks play no part here.
  assign set_pri[`TCESR_BIT_ORIENT] = (orient_q == `TCESR_ORIENT_NONE) &&
    ((orient_status == `TCESR_ORIENT_LINE1) || (orient_status == `TCESR_ORIENT_LINE2));
  assign set_pri[5] = 1'b0;
  assign set_pri[`TCESR_BIT_VBUS] = vbus_q ^ vbus_valid;
  assign set_pri[`TCESR_BIT_ASNK] = auto_sink_en & (asnk_q ^ auto_sink_active);
  assign set_pri[`TCESR_BIT_LVL] = lvl_q != current_level_status;
  // Each connected state is tracked on its own, so a direct move between two
  // connected states still reports both the exit and the entry.
  assign set_pri[`TCESR_BIT_DETACH] = |(att_state_q & ~att_state);
  assign set_pri[`TCESR_BIT_ATTACH] = |(~att_state_q & att_state);
  assign set_sec = {forced_role_fail, forced_role_done};

  assign wr_flags_pri = reg_wr_en && (reg_addr == `TCESR_ADDR_FLAGS_PRI);
  assign wr_flags_sec = reg_wr_en && (reg_addr == `TCESR_ADDR_FLAGS_SEC);

  // Write-one-to-clear; a new event in the same cycle wins over the clear.
  always @*
  begin
    flags_pri_d = flags_pri_q;
    flags_sec_d = flags_sec_q;
    if (wr_flags_pri)
    begin
      flags_pri_d = flags_pri_q & ~reg_wr_data[6:0];
    end
    if (wr_flags_sec)
    begin
      flags_sec_d = flags_sec_q & ~reg_wr_data[2:1];
    end
    flags_pri_d = flags_pri_d | set_pri;
    flags_sec_d = flags_sec_d | set_sec;
  end

  // Flags and previous-sample trackers.
  always @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      flags_pri_q <= 7'h00;
      flags_sec_q <= 2'h0;
      att_state_q <= 5'h00;
      orient_q <= `TCESR_ORIENT_NONE;
      vbus_q <= 1'b0;
      asnk_q <= 1'b0;
      lvl_q <= 2'h0;
    end
    else
    begin
      flags_pri_q <= flags_pri_d;
      flags_sec_q <= flags_sec_d;
      att_state_q <= att_state;
      orient_q <= orient_status;
      vbus_q <= vbus_valid;
      asnk_q <= auto_sink_active;
      lvl_q <= current_level_status;
    end
  end

  // Writable control, mask and user-setting registers.
  always @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      gmask_q <= `TCESR_RST_CONTROL_GMASK;
      mask_pri_q <= `TCESR_RST_MASK_PRI;
      mask_sec_q <= `TCESR_RST_MASK_SEC;
      user_q <= `TCESR_RST_USER;
    end
    else if (reg_wr_en)
    begin
      case (reg_addr)
        `TCESR_ADDR_CONTROL: gmask_q <= reg_wr_data[0];
        `TCESR_ADDR_MASK_PRI: mask_pri_q <= reg_wr_data[6:0];
        `TCESR_ADDR_MASK_SEC: mask_sec_q <= reg_wr_data[2:1];
        `TCESR_ADDR_USER: user_q <= reg_wr_data;
        default: user_q <= user_q;
      endcase
    end
  end

  // Level debounce: a new level must hold for the selected time before it counts.
  always @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      lvl_cand_q <= 2'h0;
      lvl_stable_q <= 2'h0;
      deb_cnt_q <= {CW{1'b0}};
    end
    else if (current_level_raw != lvl_cand_q)
    begin
      lvl_cand_q <= current_level_raw;
      deb_cnt_q <= {CW{1'b0}};
    end
    else if (lvl_cand_q != lvl_stable_q)
    begin
      if (deb_cnt_q >= deb_len(level_debounce_sel) - 1'b1)
      begin
        lvl_stable_q <= lvl_cand_q;
        deb_cnt_q <= {CW{1'b0}};
      end
      else
      begin
        deb_cnt_q <= deb_cnt_q + 1'b1;
      end
    end
    else
    begin
      deb_cnt_q <= {CW{1'b0}};
    end
  end

  // Discharge cap: the output drops once the cap expires, even if still requested,
  // so a stuck request cannot load VBUS forever. A new request needs the request to fall, or the cap code to go to zero, first.
  always @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      vbus_discharge_on <= 1'b0;
      dsg_cnt_q <= {CW{1'b0}};
    end
    else if (!discharge_request || (discharge_time_cap == 2'h0))
    begin
      vbus_discharge_on <= 1'b0;
      dsg_cnt_q <= {CW{1'b0}};
    end
    else if (dsg_cnt_q < dsg_len(discharge_time_cap))
    begin
      vbus_discharge_on <= 1'b1;
      dsg_cnt_q <= dsg_cnt_q + 1'b1;
    end
    else
    begin
      vbus_discharge_on <= 1'b0;
    end
  end

  // Any latched, unmasked flag pulls the interrupt low unless globally masked.
  assign pending = ~gmask_q &&
    ((|(flags_pri_q & ~mask_pri_q)) || (|(flags_sec_q & ~mask_sec_q)));

  always @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      interrupt_n <= 1'b1;
    end
    else
    begin
      interrupt_n <= ~pending;
    end
  end

  // Read mux; unmapped offsets read zero and reserved bits read zero.
  always @*
  begin
    case (reg_addr)
      `TCESR_ADDR_CONTROL: rd_mux = {7'h00, gmask_q};
      `TCESR_ADDR_MASK_PRI: rd_mux = {1'b0, mask_pri_q};
      `TCESR_ADDR_MASK_SEC: rd_mux = {5'h00, mask_sec_q, 1'b0};
      `TCESR_ADDR_STATUS: rd_mux = status_val;
      `TCESR_ADDR_CONN_TYPE: rd_mux = conn_val;
      `TCESR_ADDR_FLAGS_PRI: rd_mux = {1'b0, flags_pri_q};
      `TCESR_ADDR_FLAGS_SEC: rd_mux = {5'h00, flags_sec_q, 1'b0};
      `TCESR_ADDR_USER: rd_mux = user_q;
      default: rd_mux = 8'h00;
    endcase
  end

  // Read data is captured on the read strobe and held until the next read.
  always @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      reg_rd_data <= 8'h00;
    end
    else if (reg_rd_en)
    begin
      reg_rd_data <= rd_mux;
    end
  end

endmodule // tcesr_event_regs
`default_nettype wire

// file: tcesr_defines.vh
// Constants for the Type-C event, mask, status and connection-type registers.
// What this block does
// - Flags stay set until host writes one.
// - Flags set regardless of their mask bits.
// - Primary mask bits six..zero, reset zero.
// - Secondary mask bits two and one.
// - Orientation flag on leaving no-orientation.
// - VBUS flag on any valid change.
// - Auto-sink flag on change while enabled.
// - Current-level flag on status field change.
// - Detach flag on leaving attached states.
// - Attach flag on entering attached states.
// - Forced-role fail and done flags.
// - Attach status bit while attached.
// - Orientation status field bits five..four.
// - Current-level status in attached sink.
// - Safe-zero bit six, VBUS-valid bit three.
// - Status bit seven shows auto-sink active.
// - Connection-type role state bits six..three.
// - Active-cable bit when acting as source.
// - Audio accessory VBUS bits one, zero.
// - User bit five enables disconnect monitoring.
// - User bits three..two cap discharge time.
// - User bits one..zero select level debounce.
// - Global mask control bit zero, reset one.
// - Interrupt pin is active low.
`ifndef TCESR_DEFINES_VH
`define TCESR_DEFINES_VH

// Register offsets.
`define TCESR_ADDR_CONTROL 8'h04
`define TCESR_ADDR_MASK_PRI 8'h0E
`define TCESR_ADDR_MASK_SEC 8'h0F
`define TCESR_ADDR_STATUS 8'h11
`define TCESR_ADDR_CONN_TYPE 8'h13
`define TCESR_ADDR_FLAGS_PRI 8'h14
`define TCESR_ADDR_FLAGS_SEC 8'h15
`define TCESR_ADDR_USER 8'h16

// Reset values.
`define TCESR_RST_CONTROL_GMASK 1'b1
`define TCESR_RST_MASK_PRI 7'h00
`define TCESR_RST_MASK_SEC 2'h0
`define TCESR_RST_USER 8'h92

// Field positions.
`define TCESR_BIT_ORIENT 6
`define TCESR_BIT_VBUS 4
`define TCESR_BIT_ASNK 3
`define TCESR_BIT_LVL 2
`define TCESR_BIT_DETACH 1
`define TCESR_BIT_ATTACH 0
`define TCESR_BIT_FRC_FAIL 2
`define TCESR_BIT_FRC_DONE 1
`define TCESR_BIT_DSCNT_EN 5
`define TCESR_MSB_DSG 3
`define TCESR_LSB_DSG 2
`define TCESR_MSB_DEB 1
`define TCESR_LSB_DEB 0

// Orientation codes.
`define TCESR_ORIENT_NONE 2'h0
`define TCESR_ORIENT_LINE1 2'h1
`define TCESR_ORIENT_LINE2 2'h2

// Timing: clock rate and times in microseconds, cycle counts derived.
`define TCESR_CLK_MHZ 40
`define TCESR_T_DSG1_US 15000
`define TCESR_T_DSG2_US 50000
`define TCESR_T_DSG3_US 100000
`define TCESR_T_DEB0_US 500
`define TCESR_T_DEB1_US 3000
`define TCESR_T_DEB2_US 12000
`define TCESR_T_DEB3_US 18000
// Cycle counts are the times above at the clock rate, sized to the counter width.
`define TCESR_CYC_DSG1 23'd600000
`define TCESR_CYC_DSG2 23'd2000000
`define TCESR_CYC_DSG3 23'd4000000
`define TCESR_CYC_DEB0 23'd20000
`define TCESR_CYC_DEB1 23'd120000
`define TCESR_CYC_DEB2 23'd480000
`define TCESR_CYC_DEB3 23'd720000
`define TCESR_CNT_W 23

`endif

// file: tcesr_asserts.sv
// Concurrent checks on the ports of the event register block.
`timescale 1ns/1ps
`default_nettype none
module tcesr_asserts (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_rd_data,
  input wire logic in_attached_src,
  input wire logic in_attached_snk,
  input wire logic in_debug_sink,
  input wire logic in_audio,
  input wire logic in_debug_src,
  input wire logic [1:0] orient_status,
  input wire logic vbus_valid,
  input wire logic vbus_safe_zero,
  input wire logic auto_sink_active,
  input wire logic active_cable_seen,
  input wire logic [1:0] current_level_status,
  input wire logic [1:0] discharge_time_cap,
  input wire logic vbus_discharge_on
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // Any of the five attached states counts as attached.
  wire att_any = in_attached_src | in_attached_snk | in_debug_sink | in_audio | in_debug_src;
  wire rd_st = reg_rd_en && reg_addr == 8'h11;
  wire rd_ty = reg_rd_en && reg_addr == 8'h13;
  // Live bytes must show the inputs as they stood at the strobe edge.
  a_status_attach: assert property (rd_st |=> reg_rd_data[0] == $past(att_any))
    else $error("Attach status bit wrong.");
  a_status_orient: assert property (rd_st |=> reg_rd_data[5:4] == $past(orient_status))
    else $error("Orientation field wrong.");
  a_status_vbus: assert property (rd_st |=> reg_rd_data[3] == $past(vbus_valid) && reg_rd_data[6] == $past(vbus_safe_zero))
    else $error("VBUS status bits wrong.");
  a_status_asnk: assert property (rd_st |=> reg_rd_data[7] == $past(auto_sink_active))
    else $error("Auto-sink status bit wrong.");
  a_status_level: assert property (rd_st |=> reg_rd_data[2:1] == $past(current_level_status))
    else $error("Level field wrong.");
  a_level_gated: assert property (!in_attached_snk |-> current_level_status == 2'h0)
    else $error("Level shown outside sink state.");
  a_type_roles: assert property (rd_ty |=> reg_rd_data[6:3] == $past({in_debug_src, in_debug_sink, in_attached_snk, in_attached_src}))
    else $error("Role bits wrong.");
  a_type_cable: assert property (rd_ty |=> reg_rd_data[2] == $past(active_cable_seen && in_attached_src))
    else $error("Cable bit wrong.");
  a_type_audio: assert property (rd_ty |=> reg_rd_data[1:0] == ($past(in_audio) ? {$past(vbus_valid), !$past(vbus_valid)} : 2'h0))
    else $error("Audio bits wrong.");
  a_dsg_disabled: assert property (discharge_time_cap == 2'h0 && $past(discharge_time_cap) == 2'h0 |-> !vbus_discharge_on)
    else $error("Discharge on while disabled.");
  a_unmapped_zero: assert property (reg_rd_en && reg_addr == 8'h20 |=> reg_rd_data == 8'h00)
    else $error("Unmapped read not zero.");
endmodule // tcesr_asserts
bind tcesr_event_regs tcesr_asserts u_chk (.clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr),
  .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data), .in_attached_src(in_attached_src),
  .in_attached_snk(in_attached_snk), .in_debug_sink(in_debug_sink), .in_audio(in_audio),
  .in_debug_src(in_debug_src), .orient_status(orient_status), .vbus_valid(vbus_valid),
  .vbus_safe_zero(vbus_safe_zero), .auto_sink_active(auto_sink_active), .active_cable_seen(active_cable_seen),
  .current_level_status(current_level_status), .discharge_time_cap(discharge_time_cap),
  .vbus_discharge_on(vbus_discharge_on));
`default_nettype wire

// file: tcesr_host_model.sv
// Host model that issues register strobes to the event block.
`timescale 1ns/1ps
`default_nettype none
module tcesr_host_model (
  input wire logic clk_sys,
  input wire logic [7:0] reg_rd_data,
  output logic [7:0] reg_addr,
  output logic reg_wr_en,
  output logic [7:0] reg_wr_data,
  output logic reg_rd_en
);
  // Idle bus at time zero.
  initial
  begin
    reg_addr = 8'h00;
    reg_wr_en = 1'b0;
    reg_wr_data = 8'h00;
    reg_rd_en = 1'b0;
  end
  // Released data shows the inverse so a stale byte is never mistaken for a write.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wr_data <= d;
    reg_wr_en <= 1'b1;
    @(posedge clk_sys);
    reg_wr_en <= 1'b0;
    reg_wr_data <= ~d;
  endtask
  // Read data is taken just after the edge that samples the strobe.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd_en <= 1'b1;
    @(posedge clk_sys);
    reg_rd_en <= 1'b0;
    #1 d = reg_rd_data;
  endtask
endmodule // tcesr_host_model
`default_nettype wire

// file: tb_top.sv
// Register-level testbench for the event register block.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] reg_addr, reg_wr_data, reg_rd_data, v;
  logic reg_wr_en, reg_rd_en, dsg_on, mon_en, int_n;
  logic att_src = 0, att_snk = 0, dbg_snk = 0, audio = 0, dbg_src = 0, cable = 0, dsg_req = 0;
  logic vbus = 0, safe0 = 0, asnk_en = 0, asnk_act = 0, frc_fail = 0, frc_done = 0;
  logic [1:0] orient = 2'h0, lvl_raw = 2'h0, lvl_st, cap, deb;
  int err_count = 0, cmp_count = 0, cyc = 0, n;
  always #12.5 clk_sys = ~clk_sys;
  // Only debounce code 2 and discharge code 1, the codes that the timed tests run under, are shortened.
  tcesr_event_regs #(.DSG1_CYC(23'h8), .DEB2_CYC(23'h8)) DUT (.clk_sys(clk_sys), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en),
    .reg_rd_data(reg_rd_data), .in_attached_src(att_src), .in_attached_snk(att_snk), .in_debug_sink(dbg_snk),
    .in_audio(audio), .in_debug_src(dbg_src), .orient_status(orient), .vbus_valid(vbus), .vbus_safe_zero(safe0),
    .auto_sink_en(asnk_en), .auto_sink_active(asnk_act), .current_level_raw(lvl_raw), .active_cable_seen(cable),
    .forced_role_fail(frc_fail), .forced_role_done(frc_done), .discharge_request(dsg_req),
    .vbus_discharge_on(dsg_on), .line_disconnect_monitor_en(mon_en), .level_debounce_sel(deb),
    .discharge_time_cap(cap), .current_level_status(lvl_st), .interrupt_n(int_n));
  tcesr_host_model HOST (.clk_sys(clk_sys), .reg_rd_data(reg_rd_data), .reg_addr(reg_addr),
    .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en));
  task automatic final_report;
    $display("Compares %0d, mismatches %0d.", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    HOST.rd(a, v);
    chk(v, exp);
  endtask
  // An unmasked event pulls the pin low; a zero write must not clear it, a one write must.
  task automatic ev(input logic [7:0] a, input logic [7:0] m);
    repeat (3) @(posedge clk_sys);
    #1 chk({7'h0, int_n}, 8'h00);
    HOST.wr(a, 8'h00);
    rdchk(a, m);
    HOST.wr(a, m);
    rdchk(a, 8'h00);
    #1 chk({7'h0, int_n}, 8'h01);
  endtask
  // The hang guard allows several times the expected run.
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      err_count++;
      final_report;
    end
  end
  initial
  begin
    repeat (4) @(posedge clk_sys);
    reset_n <= 1'b1;
    rdchk(8'h04, 8'h01);
    rdchk(8'h0E, 8'h00);
    rdchk(8'h0F, 8'h00);
    rdchk(8'h16, 8'h92);
    chk({3'h0, mon_en, cap, deb}, 8'h02);
    rdchk(8'h20, 8'h00);
    HOST.wr(8'h04, 8'h00);
    $display("Test reset values ended.");
    @(posedge clk_sys) vbus <= 1'b1;
    ev(8'h14, 8'h10);
    @(posedge clk_sys) vbus <= 1'b0;
    ev(8'h14, 8'h10);
    @(posedge clk_sys) att_snk <= 1'b1;
    ev(8'h14, 8'h01);
    rdchk(8'h13, 8'h10);
    @(posedge clk_sys) lvl_raw <= 2'h3;
    repeat (20) @(posedge clk_sys);
    ev(8'h14, 8'h04);
    rdchk(8'h11, 8'h07);
    @(posedge clk_sys) att_snk <= 1'b0;
    ev(8'h14, 8'h06);
    for (int i = 1; i < 3; i++)
    begin
      @(posedge clk_sys) orient <= i[1:0];
      ev(8'h14, 8'h40);
      @(posedge clk_sys) orient <= 2'h0;
      rdchk(8'h14, 8'h00);
      @(posedge clk_sys) {frc_fail, frc_done} <= i[1:0];
      @(posedge clk_sys) {frc_fail, frc_done} <= 2'h0;
      ev(8'h15, {5'h0, i[1:0], 1'b0});
    end
    @(posedge clk_sys) asnk_en <= 1'b1;
    @(posedge clk_sys) asnk_act <= 1'b1;
    ev(8'h14, 8'h08);
    $display("Test single events ended.");
    @(posedge clk_sys) {audio, vbus} <= 2'h3;
    ev(8'h14, 8'h11);
    rdchk(8'h13, 8'h02);
    @(posedge clk_sys) vbus <= 1'b0;
    ev(8'h14, 8'h10);
    rdchk(8'h13, 8'h01);
    @(posedge clk_sys) {audio, att_src, cable} <= 3'h3;
    ev(8'h14, 8'h03);
    rdchk(8'h13, 8'h0C);
    @(posedge clk_sys) {att_src, cable, dbg_snk} <= 3'h1;
    ev(8'h14, 8'h03);
    rdchk(8'h13, 8'h20);
    @(posedge clk_sys) {dbg_snk, dbg_src, safe0} <= 3'h3;
    ev(8'h14, 8'h03);
    rdchk(8'h13, 8'h40);
    rdchk(8'h11, 8'hC1);
    @(posedge clk_sys) dbg_src <= 1'b0;
    ev(8'h14, 8'h02);
    $display("Test connection types ended.");
    HOST.wr(8'h0E, 8'h10);
    @(posedge clk_sys) vbus <= 1'b1;
    repeat (4) @(posedge clk_sys);
    #1 chk({7'h0, int_n}, 8'h01);
    rdchk(8'h14, 8'h10);
    HOST.wr(8'h0E, 8'h00);
    repeat (2) @(posedge clk_sys);
    #1 chk({7'h0, int_n}, 8'h00);
    HOST.wr(8'h04, 8'h01);
    repeat (2) @(posedge clk_sys);
    #1 chk({7'h0, int_n}, 8'h01);
    HOST.wr(8'h04, 8'h00);
    HOST.wr(8'h14, 8'h10);
    HOST.wr(8'h0F, 8'hFF);
    rdchk(8'h0F, 8'h06);
    $display("Test masks ended.");
    HOST.wr(8'h16, 8'h25);
    #1 chk({3'h0, mon_en, cap, deb}, 8'h15);
    @(posedge clk_sys) dsg_req <= 1'b1;
    n = 0;
    repeat (30)
    begin
      @(posedge clk_sys);
      #1 if (dsg_on === 1'b1) n++;
    end
    chk(n[7:0], 8'h08);
    // A fresh request with the cap code at zero must leave discharge off.
    HOST.wr(8'h16, 8'h21);
    @(posedge clk_sys) dsg_req <= 1'b0;
    @(posedge clk_sys) dsg_req <= 1'b1;
    repeat (4) @(posedge clk_sys);
    #1 chk({7'h0, dsg_on}, 8'h00);
    $display("Test user settings ended.");
    final_report;
  end
endmodule // tb_top
`default_nettype wire
